// ---- logic/lpsq_sequencer.sv ----
// Local design decision: the plain strobed port.
`timescale 1ns/1ps
module lpsq_sequencer
    import lpsq_pkg::*;
(
    // Clock and reset
    input wire logic CLK,
    input wire logic RESET_N,
    // Register port
    input wire logic [7:0] ADDR,
    input wire logic [15:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [15:0] RDATA,
    // Transmit side, same clock
    input wire logic TX_REQ,
    input wire logic TX_DONE,
    output logic TX_ACTIVE,
    // Receive carrier, from the line
    input wire logic RX_CARRIER,
    output logic RX_ACTIVE,
    // Queue state from packet memory manager
    input wire logic TXQ_EMPTY,
    input wire logic RXQ_EMPTY,
    input wire logic ALL_FREE,
    // PHY and line
    output logic TP_OE,
    output logic PHY_POWERDOWN,
    output logic PHY_ISOLATE,
    // Clock gate enables
    output logic RX_CLK_EN,
    output logic TX_CLK_EN,
    output logic CORE_CLK_EN,
    output logic LOW_POWER
);
    logic [15:0] cfg;
    logic tx_enable;
    logic rx_enable;
    logic phy_pdn;
    logic phy_iso;
    logic carrier_m;
    logic carrier_s;
    logic carrier_d;
    logic tx_active;
    logic rx_active;
    logic [15:0] rdata;
    logic tp_oe;
    logic low_power;
    lpsq_state_e state;
    lpsq_state_e next_state;
    logic rx_en_g;
    logic tx_en_g;
    logic core_en_g;

    function automatic logic hit(input logic [7:0] a,
                                 input logic [7:0] off);
        hit = (a == off);
    endfunction

    // Address decode
    wire wr_cfg = WR && hit(ADDR, LPSQ_OFF_CFG);
    wire wr_tx = WR && hit(ADDR, LPSQ_OFF_TXCTL);
    wire wr_rx = WR && hit(ADDR, LPSQ_OFF_RXCTL);
    wire wr_phy = WR && hit(ADDR, LPSQ_OFF_PHYCTL);
    wire power_on = cfg[LPSQ_CFG_PWR_BIT];

    // Queues drained and every packet number back in the pool
    wire buffers_free = TXQ_EMPTY && RXQ_EMPTY && ALL_FREE;

    wire [15:0] status_word = {
        10'h000,
        core_en_g,
        buffers_free,
        low_power,
        phy_pdn,
        rx_active,
        tx_active
    };

    wire [15:0] phy_word = {
        4'h0,
        phy_pdn,
        phy_iso,
        10'h000
    };

    // Readback mux; bus runs on the free clock, never gated
    wire [15:0] next_rdata =
        hit(ADDR, LPSQ_OFF_CFG) ? cfg :
        hit(ADDR, LPSQ_OFF_TXCTL) ? {15'h0000, tx_enable} :
        hit(ADDR, LPSQ_OFF_RXCTL) ? {15'h0000, rx_enable} :
        hit(ADDR, LPSQ_OFF_PHYCTL) ? phy_word :
        hit(ADDR, LPSQ_OFF_STATUS) ? status_word :
        16'h0000;

    // Isolate: set when powerdown is released, set beats clear
    wire pdn_release = wr_phy && phy_pdn && !WDATA[LPSQ_PHY_PDN_BIT];
    wire next_iso = pdn_release ? 1'b1 :
        wr_phy ? WDATA[LPSQ_PHY_ISO_BIT] : phy_iso;

    // Frames start only with enable and a running core clock
    wire tx_start = tx_enable && TX_REQ && core_en_g;
    wire next_tx_active = tx_active ? !TX_DONE : tx_start;

    wire rx_edge = carrier_s && !carrier_d;
    wire rx_start = rx_enable && rx_edge && core_en_g;
    wire next_rx_active = rx_active ? carrier_s : rx_start;

    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            cfg <= LPSQ_CFG_RESET;
            tx_enable <= LPSQ_TX_ENA_RESET;
            rx_enable <= LPSQ_RX_ENA_RESET;
            phy_pdn <= LPSQ_PDN_RESET;
            phy_iso <= LPSQ_ISO_RESET;
        end else begin
            if (wr_cfg) begin
                cfg <= WDATA;
            end
            if (wr_tx) begin
                tx_enable <= WDATA[LPSQ_TX_ENA_BIT];
            end
            if (wr_rx) begin
                rx_enable <= WDATA[LPSQ_RX_ENA_BIT];
            end
            if (wr_phy) begin
                phy_pdn <= WDATA[LPSQ_PHY_PDN_BIT];
            end
            phy_iso <= next_iso;
        end
    end

    // Carrier is a pin; two flops before any use
    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            carrier_m <= 1'b0;
            carrier_s <= 1'b0;
            carrier_d <= 1'b0;
        end else begin
            carrier_m <= RX_CARRIER;
            carrier_s <= carrier_m;
            carrier_d <= carrier_s;
        end
    end

    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            tx_active <= 1'b0;
            rx_active <= 1'b0;
        end else begin
            tx_active <= next_tx_active;
            rx_active <= next_rx_active;
        end
    end

    // Power sequencing
    // Power may return mid-sequence; never strand a state
    always_comb begin
        next_state = state;
        case (state)
            LPSQ_RUN: begin
                if (!power_on) begin
                    next_state = LPSQ_GATING;
                end
            end
            LPSQ_GATING: begin
                if (power_on) begin
                    next_state = LPSQ_UNGATING;
                end else if (!core_en_g) begin
                    next_state = LPSQ_LOW;
                end
            end
            LPSQ_LOW: begin
                if (power_on) begin
                    next_state = LPSQ_UNGATING;
                end
            end
            LPSQ_UNGATING: begin
                if (rx_en_g) begin
                    next_state = LPSQ_RUN;
                end else if (!power_on) begin
                    next_state = LPSQ_GATING;
                end
            end
            default: begin
                next_state = LPSQ_RUN;
            end
        endcase
    end

    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            state <= LPSQ_RUN;
            low_power <= 1'b0;
        end else begin
            state <= next_state;
            low_power <= (next_state == LPSQ_LOW);
        end
    end

    // Line drivers released while the PHY sleeps
    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            tp_oe <= 1'b1;
            rdata <= 16'h0000;
        end else begin
            tp_oe <= !phy_pdn;
            rdata <= RD ? next_rdata : 16'h0000;
        end
    end

    lpsq_clk_gate u_gate (
        .clk(CLK),
        .reset_n(RESET_N),
        .want_on(power_on),
        .rx_en(rx_en_g),
        .tx_en(tx_en_g),
        .core_en(core_en_g)
    );

    assign RDATA = rdata;
    assign TX_ACTIVE = tx_active;
    assign RX_ACTIVE = rx_active;
    assign TP_OE = tp_oe;
    assign PHY_POWERDOWN = phy_pdn;
    assign PHY_ISOLATE = phy_iso;
    assign RX_CLK_EN = rx_en_g;
    assign TX_CLK_EN = tx_en_g;
    assign CORE_CLK_EN = core_en_g;
    assign LOW_POWER = low_power;

    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RESET_N);

    sequence gate_off_s;
        !RX_CLK_EN && !TX_CLK_EN ##1 !CORE_CLK_EN;
    endsequence

    sequence gate_on_s;
        CORE_CLK_EN ##1 RX_CLK_EN && TX_CLK_EN;
    endsequence

    tx_finish_a: assert property (
        TX_ACTIVE && !TX_DONE |=> TX_ACTIVE)
        else $error("transmit cut before frame end");

    tx_stop_a: assert property (
        TX_ACTIVE && TX_DONE && !tx_start |=> !TX_ACTIVE)
        else $error("transmit did not stop at frame end");

    rx_finish_a: assert property (
        RX_ACTIVE && carrier_s |=> RX_ACTIVE)
        else $error("receive cut mid frame");

    rx_idle_a: assert property (
        !rx_enable && !RX_ACTIVE |=> !RX_ACTIVE)
        else $error("disabled receiver took a frame");

    tp_hiz_a: assert property (
        $rose(PHY_POWERDOWN) |=> !TP_OE)
        else $error("line outputs driven in powerdown");

    isolate_set_a: assert property (
        $fell(PHY_POWERDOWN) |-> PHY_ISOLATE)
        else $error("isolate not set on powerdown release");

    gate_off_a: assert property (
        $fell(power_on) ##0 CORE_CLK_EN |=> gate_off_s)
        else $error("clocks not gated after power clear");

    gate_on_a: assert property (
        $rose(power_on) ##0 !CORE_CLK_EN |=> gate_on_s)
        else $error("clocks not restored after power set");

    bus_live_a: assert property (
        RD && hit(ADDR, LPSQ_OFF_CFG) && !WR
        |=> RDATA == $past(cfg))
        else $error("config read failed");

    tx_start_a: assert property (
        !TX_ACTIVE && tx_enable && TX_REQ && CORE_CLK_EN
        |=> TX_ACTIVE)
        else $error("enabled transmitter did not start");

    rx_start_a: assert property (
        !RX_ACTIVE && rx_enable && rx_edge && CORE_CLK_EN
        |=> RX_ACTIVE)
        else $error("enabled receiver missed frame");

    low_flag_a: assert property (
        LOW_POWER |-> !CORE_CLK_EN && !RX_CLK_EN)
        else $error("low power flagged with clocks running");

    low_entry_a: assert property (
        $fell(CORE_CLK_EN) && !power_on |=> LOW_POWER)
        else $error("low power not flagged after core stop");

    low_exit_a: assert property (
        $rose(power_on) |=> !LOW_POWER)
        else $error("low power flag held after power set");

    tx_gated_a: assert property (
        !CORE_CLK_EN && !TX_ACTIVE |=> !TX_ACTIVE)
        else $error("transmit started on stopped core clock");

    rdata_idle_a: assert property (
        !RD |=> RDATA == 16'h0000)
        else $error("read data left standing");

    cfg_write_a: assert property (
        wr_cfg |=> cfg == $past(WDATA))
        else $error("config write lost");

    pdn_write_a: assert property (
        wr_phy |=> PHY_POWERDOWN == $past(WDATA[LPSQ_PHY_PDN_BIT]))
        else $error("powerdown write lost");

    iso_write_a: assert property (
        wr_phy && !pdn_release
        |=> PHY_ISOLATE == $past(WDATA[LPSQ_PHY_ISO_BIT]))
        else $error("isolate write lost");

    free_flag_a: assert property (
        RD && hit(ADDR, LPSQ_OFF_STATUS) && buffers_free
        |=> RDATA[LPSQ_ST_FREE_BIT])
        else $error("free pool not reported");
endmodule

// ---- logic/lpsq_pkg.sv ----
package lpsq_pkg;
    // Register byte offsets
    localparam logic [7:0] LPSQ_OFF_CFG = 8'h00;
    localparam logic [7:0] LPSQ_OFF_TXCTL = 8'h04;
    localparam logic [7:0] LPSQ_OFF_RXCTL = 8'h08;
    localparam logic [7:0] LPSQ_OFF_PHYCTL = 8'h0c;
    localparam logic [7:0] LPSQ_OFF_STATUS = 8'h10;

    // Field positions
    localparam int LPSQ_CFG_PWR_BIT = 15;
    localparam int LPSQ_TX_ENA_BIT = 0;
    localparam int LPSQ_RX_ENA_BIT = 0;
    localparam int LPSQ_PHY_PDN_BIT = 11;
    localparam int LPSQ_PHY_ISO_BIT = 10;
    localparam int LPSQ_ST_TXACT_BIT = 0;
    localparam int LPSQ_ST_RXACT_BIT = 1;
    localparam int LPSQ_ST_PDN_BIT = 2;
    localparam int LPSQ_ST_GATED_BIT = 3;
    localparam int LPSQ_ST_FREE_BIT = 4;
    localparam int LPSQ_ST_CLKON_BIT = 5;

    // Reset values
    localparam logic [15:0] LPSQ_CFG_RESET = 16'h8000;
    localparam logic LPSQ_TX_ENA_RESET = 1'b0;
    localparam logic LPSQ_RX_ENA_RESET = 1'b0;
    localparam logic LPSQ_PDN_RESET = 1'b0;
    localparam logic LPSQ_ISO_RESET = 1'b0;

    // Cycles between gate stages
    localparam int LPSQ_GATE_STEP = 1;

    typedef enum logic [1:0] {
        LPSQ_RUN,
        LPSQ_GATING,
        LPSQ_LOW,
        LPSQ_UNGATING
    } lpsq_state_e;
endpackage

// ---- logic/lpsq_clk_gate.sv ----
`timescale 1ns/1ps
module lpsq_clk_gate
    import lpsq_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Request
    input wire logic want_on,
    // Registered enables
    output logic rx_en,
    output logic tx_en,
    output logic core_en
);
    // Off: line clocks drop first, core last. On: core first.
    // Enables only change on a registered edge, so a gate cell
    // fed from them never sees a runt pulse.
    wire next_core = want_on | rx_en | tx_en;
    wire next_line = want_on & core_en;

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            rx_en <= 1'b1;
            tx_en <= 1'b1;
            core_en <= 1'b1;
        end else begin
            rx_en <= next_line;
            tx_en <= next_line;
            core_en <= next_core;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    sequence line_off_s;
        !rx_en && !tx_en;
    endsequence

    core_order_a: assert property (
        $fell(core_en) |-> $past(!rx_en) && $past(!tx_en))
        else $error("core clock stopped before line clocks");
    line_order_a: assert property (
        $rose(rx_en) |-> $past(core_en))
        else $error("line clock started before core clock");
    off_seq_a: assert property (
        $fell(want_on) ##0 core_en |-> ##1 line_off_s ##1 !core_en)
        else $error("gate off sequence broken");
endmodule

// ---- sim/lpsq_line_model.sv ----
`timescale 1ns/1ps
module lpsq_line_model #(
    parameter int FRAME_LEN = 20
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Transmit handshake
    input wire logic tx_active,
    output logic tx_done
);
    // Fixed frame length keeps expectations simple
    logic [7:0] count;

    always_ff @(posedge clk) begin
        if (!reset_n || !tx_active || tx_done) begin
            count <= 8'h00;
            tx_done <= 1'b0;
        end else begin
            count <= count + 8'h01;
            tx_done <= (count == 8'(FRAME_LEN - 2));
        end
    end
endmodule

// ---- sim/lpsq_sequencer_tb.sv ----
`timescale 1ns/1ps
module lpsq_sequencer_tb;
    import lpsq_pkg::*;
    logic clk, reset_n, wr, rd, tx_req, rx_carrier;
    logic txq_empty, rxq_empty, all_free, tx_done, tx_active, rx_active;
    logic tp_oe, phy_pd, phy_iso, rx_ce, tx_ce, core_ce, low_pw;
    logic [7:0] addr;
    logic [15:0] wdata, rdata;
    logic [6:0] pins;
    int failures, checked;

    assign pins = {tp_oe, phy_pd, phy_iso, rx_ce, tx_ce, core_ce, low_pw};

    lpsq_sequencer dut (.CLK(clk), .RESET_N(reset_n), .ADDR(addr),
        .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata), .TX_REQ(tx_req),
        .TX_DONE(tx_done), .TX_ACTIVE(tx_active), .RX_CARRIER(rx_carrier),
        .RX_ACTIVE(rx_active), .TXQ_EMPTY(txq_empty), .RXQ_EMPTY(rxq_empty),
        .ALL_FREE(all_free), .TP_OE(tp_oe), .PHY_POWERDOWN(phy_pd),
        .PHY_ISOLATE(phy_iso), .RX_CLK_EN(rx_ce), .TX_CLK_EN(tx_ce),
        .CORE_CLK_EN(core_ce), .LOW_POWER(low_pw));

    lpsq_line_model #(.FRAME_LEN(20)) line (.clk(clk), .reset_n(reset_n),
        .tx_active(tx_active), .tx_done(tx_done));

    task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        checked++;
        if (g !== e) begin
            failures++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask

    task tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task wr_reg(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    // Also checks that read data drops back to zero
    task rd_chk(input string nm, input logic [7:0] a, input logic [15:0] e);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        chk(nm, e, rdata);
        tick(1);
        chk(nm, 16'h0000, rdata);
    endtask

    task print_verdict;
        if (failures == 0 && checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    initial begin
        repeat (5000) @(posedge clk);
        failures++;
        print_verdict;
    end

    initial begin
        reset_n = 1'b0;
        {wr, rd, tx_req, rx_carrier} = 4'h0;
        {txq_empty, rxq_empty, all_free} = 3'h0;
        addr = 8'h00;
        wdata = 16'h0000;
        failures = 0;
        checked = 0;
        repeat (10) @(posedge clk);
        reset_n <= 1'b1;
        tick(1);
        chk("reset pins", 16'h004e, {9'h000, pins});
        rd_chk("cfg", LPSQ_OFF_CFG, LPSQ_CFG_RESET);
        rd_chk("unmapped", 8'h20, 16'h0000);
        rd_chk("status", LPSQ_OFF_STATUS, 16'h0020);
        // Stop request lands mid-frame, request stays pending
        wr_reg(LPSQ_OFF_TXCTL, 16'h0001);
        @(posedge clk) tx_req <= 1'b1;
        for (int i = 0; i < 8 && tx_active !== 1'b1; i++) tick(1);
        wr_reg(LPSQ_OFF_TXCTL, 16'h0000);
        tick(0);
        chk("tx hold", 16'h0001, {15'h0, tx_active});
        for (int i = 0; i < 40 && tx_done !== 1'b1; i++) tick(1);
        tick(1);
        chk("tx stop", 16'h0000, {15'h0, tx_active});
        tick(4);
        chk("tx idle", 16'h0000, {15'h0, tx_active});
        wr_reg(LPSQ_OFF_RXCTL, 16'h0001);
        @(posedge clk) rx_carrier <= 1'b1;
        tick(5);
        chk("rx start", 16'h0001, {15'h0, rx_active});
        wr_reg(LPSQ_OFF_RXCTL, 16'h0000);
        tick(2);
        chk("rx finish", 16'h0001, {15'h0, rx_active});
        @(posedge clk) rx_carrier <= 1'b0;
        tick(6);
        chk("rx end", 16'h0000, {15'h0, rx_active});
        @(posedge clk) rx_carrier <= 1'b1;
        tick(6);
        chk("rx refuse", 16'h0000, {15'h0, rx_active});
        @(posedge clk) rx_carrier <= 1'b0;
        @(posedge clk) {txq_empty, rxq_empty, all_free} <= 3'h7;
        // Interrupt status sits outside this block; write is ignored
        wr_reg(8'h14, 16'h0000);
        rd_chk("status free", LPSQ_OFF_STATUS, 16'h0030);
        rd_chk("save tx", LPSQ_OFF_TXCTL, 16'h0000);
        rd_chk("save rx", LPSQ_OFF_RXCTL, 16'h0000);
        wr_reg(LPSQ_OFF_PHYCTL, 16'h0800);
        tick(1);
        chk("pdn pins", 16'h002e, {9'h000, pins});
        rd_chk("phy pdn", LPSQ_OFF_PHYCTL, 16'h0800);
        rd_chk("status pdn", LPSQ_OFF_STATUS, 16'h0034);
        wr_reg(LPSQ_OFF_CFG, 16'h0000);
        tick(0);
        chk("gate c1", 16'h002e, {9'h000, pins});
        tick(1);
        chk("gate c2", 16'h0022, {9'h000, pins});
        tick(1);
        chk("gate c3", 16'h0020, {9'h000, pins});
        tick(1);
        chk("gate c4", 16'h0021, {9'h000, pins});
        rd_chk("cfg low", LPSQ_OFF_CFG, 16'h0000);
        // Enabled transmitter must not start on a stopped core clock
        wr_reg(LPSQ_OFF_TXCTL, 16'h0001);
        tick(4);
        chk("tx gated", 16'h0000, {15'h0, tx_active});
        // Pool state is stale until the memory manager is reset
        @(posedge clk) {txq_empty, rxq_empty, all_free} <= 3'h0;
        wr_reg(LPSQ_OFF_CFG, 16'h8000);
        tick(1);
        chk("ungate c2", 16'h0001, {13'h0, rx_ce, tx_ce, core_ce});
        tick(1);
        chk("ungate c3", 16'h0007, {13'h0, rx_ce, tx_ce, core_ce});
        tick(2);
        chk("awake", 16'h0000, {15'h0, low_pw});
        chk("tx wake", 16'h0001, {15'h0, tx_active});
        wr_reg(LPSQ_OFF_PHYCTL, 16'h0000);
        tick(1);
        chk("isolate", 16'h0005, {13'h0, tp_oe, phy_pd, phy_iso});
        rd_chk("phy iso", LPSQ_OFF_PHYCTL, 16'h0400);
        wr_reg(LPSQ_OFF_PHYCTL, 16'h0000);
        tick(1);
        chk("iso clear", 16'h0004, {13'h0, tp_oe, phy_pd, phy_iso});
        @(posedge clk) {txq_empty, rxq_empty, all_free} <= 3'h7;
        rd_chk("status mmu", LPSQ_OFF_STATUS, 16'h0031);
        // Restore saved context; frame in flight still runs out
        wr_reg(LPSQ_OFF_TXCTL, 16'h0000);
        for (int i = 0; i < 40 && tx_active !== 1'b0; i++) tick(1);
        chk("tx end", 16'h0000, {15'h0, tx_active});
        wr_reg(LPSQ_OFF_TXCTL, 16'h0001);
        tick(1);
        chk("tx again", 16'h0001, {15'h0, tx_active});
        wr_reg(LPSQ_OFF_RXCTL, 16'h0001);
        @(posedge clk) rx_carrier <= 1'b1;
        tick(5);
        chk("rx wake", 16'h0001, {15'h0, rx_active});
        @(posedge clk) rx_carrier <= 1'b0;
        tick(2);
        print_verdict;
    end
endmodule
